// file: verilog/aops_pkg.sv
// constants shared by the analog and pulse output scaler
package aops_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int SRC_W = 16;
   localparam int SRC_N = 17;
   localparam logic [4:0] SRC_CODE_MAX = 5'h10;
   localparam logic [4:0] SRC_ABS_TORQUE = 5'h03;
   localparam logic [4:0] SRC_SIGNED_TORQUE = 5'h10;
   // parameter address: high byte is the group, low byte the index
   localparam logic [7:0] GROUP_STORE = 8'hF5;
   localparam logic [7:0] GROUP_VOLATILE = 8'h05;
   localparam logic [7:0] IDX_TERM_MODE = 8'h00;
   localparam logic [7:0] IDX_PULSE_SRC = 8'h06;
   localparam logic [7:0] IDX_AO1_SRC = 8'h07;
   localparam logic [7:0] IDX_AO2_SRC = 8'h08;
   localparam logic [7:0] IDX_PULSE_MAX = 8'h09;
   localparam logic [7:0] IDX_AO1_OFS = 8'h0A;
   localparam logic [7:0] IDX_AO1_GAIN = 8'h0B;
   localparam logic [7:0] IDX_AO2_OFS = 8'h0C;
   localparam logic [7:0] IDX_AO2_GAIN = 8'h0D;
   // read-only state
   localparam logic [7:0] IDX_PULSE_FREQ = 8'h20;
   localparam logic [7:0] IDX_AO1_PCT = 8'h21;
   localparam logic [7:0] IDX_AO2_PCT = 8'h22;
   localparam logic [7:0] IDX_PULSE_PCT = 8'h23;
   // terminal modes
   localparam logic TERM_PULSE = 1'b0;
   localparam logic TERM_DIGITAL = 1'b1;
   // reset values
   localparam logic TERM_MODE_RST = 1'b0;
   localparam logic [4:0] PULSE_SRC_RST = 5'h00;
   localparam logic [4:0] AO1_SRC_RST = 5'h00;
   localparam logic [4:0] AO2_SRC_RST = 5'h01;
   // pulse frequency in 0.01 kHz steps
   localparam int FREQ_LSB_HZ = 10;
   localparam logic [15:0] FREQ_MIN = 16'h0001;
   localparam logic [15:0] FREQ_MAX = 16'h2710;
   localparam logic [15:0] FREQ_RST = 16'h1388;
   // offset in 0.1 %, gain in 0.01
   localparam logic signed [15:0] OFS_MIN = -16'sd1000;
   localparam logic signed [15:0] OFS_MAX = 16'sd1000;
   localparam logic signed [15:0] OFS_RST = 16'sd0;
   localparam logic signed [15:0] GAIN_MIN = -16'sd1000;
   localparam logic signed [15:0] GAIN_MAX = 16'sd1000;
   localparam logic signed [15:0] GAIN_RST = 16'sd100;
   localparam int GAIN_UNIT = 100;
   localparam logic [10:0] PCT_FULL = 11'h3E8;
   // full output: mV in voltage mode, uA in current mode
   localparam logic [15:0] YMAX_MV = 16'h2710;
   localparam logic [15:0] YMAX_UA = 16'h4E20;
   // phase step per 0.01 kHz, 10 fractional bits
   localparam int NCO_FRAC = 10;
   localparam longint NCO_GAIN = ((64'd1 << (32 + NCO_FRAC)) * FREQ_LSB_HZ) / CLK_HZ;
endpackage

// file: verilog/aops_analog_out.sv
// one analog output path: gain, zero offset, clamp and full-scale selection
`timescale 1ns/1ps
`default_nettype none
module aops_analog_out (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic [10:0] pct,
   input wire logic signed [15:0] gain,
   input wire logic signed [15:0] ofs,
   input wire logic current_mode,
   output logic [15:0] level
);
   typedef struct packed {
      logic [15:0] level;
   } aops_ao_st_t;

   aops_ao_st_t st_r;
   aops_ao_st_t st_nxt;
   logic signed [31:0] y;
   logic [31:0] scaled;
   logic [15:0] ymax;

   localparam logic signed [31:0] GAIN_UNIT_S = 32'(aops_pkg::GAIN_UNIT);
   localparam logic signed [31:0] PCT_FULL_S = 32'(aops_pkg::PCT_FULL);

   always_comb begin
      st_nxt = st_r;
      // offset of 1000 (100 %) is full output
      y = (gain * $signed({21'h00_0000, pct})) / GAIN_UNIT_S + 32'(ofs);
      if (y < 32'sd0) begin
         y = 32'sd0;
      end else if (y > 32'(PCT_FULL_S)) begin
         y = 32'(PCT_FULL_S);
      end
      ymax = current_mode ? aops_pkg::YMAX_UA : aops_pkg::YMAX_MV;
      scaled = (32'(y) * {16'h0000, ymax}) / 32'(aops_pkg::PCT_FULL);
      st_nxt.level = scaled[15:0];
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.level;
endmodule
`default_nettype wire

// file: verilog/aops_pulse_gen.sv
// phase-accumulator pulse generator for the shared frequency terminal
`timescale 1ns/1ps
`default_nettype none
module aops_pulse_gen (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic enable,
   input wire logic [15:0] freq,
   output logic pulse
);
   typedef struct packed {
      logic [31:0] acc;
      logic pulse;
   } aops_pg_st_t;

   aops_pg_st_t st_r;
   aops_pg_st_t st_nxt;
   logic [63:0] step_wide;

   always_comb begin
      st_nxt = st_r;
      // step truncates: frequency error below 0.1 % at the top of the range
      step_wide = (64'(freq) * 64'(aops_pkg::NCO_GAIN)) >> aops_pkg::NCO_FRAC;
      if (enable) begin
         st_nxt.acc = st_r.acc + step_wide[31:0];
         st_nxt.pulse = st_r.acc[31];
      end else begin
         st_nxt.acc = 32'h0000_0000;
         st_nxt.pulse = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulse = st_r.pulse;
endmodule
`default_nettype wire

// file: verilog/aops_top.sv
// parameter store, source selection and scaling for pulse and analog outputs
`timescale 1ns/1ps
`default_nettype none
module aops_top #(
   parameter int SRC_N = aops_pkg::SRC_N,
   parameter int SRC_W = aops_pkg::SRC_W
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic PARAM_WE,
   input wire logic [15:0] PARAM_ADDR,
   input wire logic [15:0] PARAM_WDATA,
   output logic [15:0] PARAM_RDATA,
   output logic PARAM_REJECT,
   input wire logic [SRC_N*SRC_W-1:0] SRC_VALUE,
   input wire logic [SRC_N*SRC_W-1:0] SRC_FULL_SCALE,
   input wire logic AO1_CURRENT_MODE,
   input wire logic AO2_CURRENT_MODE,
   input wire logic SHARED_TERMINAL_DIGITAL_OUT,
   output logic SHARED_FREQ_TERMINAL,
   output logic [15:0] ANALOG_OUT_FIRST,
   output logic [15:0] ANALOG_OUT_SECOND
);
   typedef struct packed {
      logic term_mode;
      logic [4:0] pulse_src;
      logic [4:0] ao1_src;
      logic [4:0] ao2_src;
      logic [15:0] pulse_max;
      logic signed [15:0] ao1_ofs;
      logic signed [15:0] ao1_gain;
      logic signed [15:0] ao2_ofs;
      logic signed [15:0] ao2_gain;
      logic [10:0] pulse_pct;
      logic [10:0] ao1_pct;
      logic [10:0] ao2_pct;
      logic [15:0] pulse_freq;
      logic [15:0] rdata;
      logic reject;
   } aops_top_st_t;

   aops_top_st_t st_r;
   aops_top_st_t st_nxt;

   logic signed [SRC_W-1:0] src_v [SRC_N];
   logic [SRC_W-1:0] src_fs [SRC_N];
   logic addr_hit;
   logic [7:0] idx;
   logic signed [15:0] wsig;
   logic sel_ok;
   logic [31:0] freq_span;
   logic pulse_wave;

   // every source arrives already in the units of its own range
   for (genvar g = 0; g < SRC_N; g++) begin : g_src
      assign src_v[g] = $signed(SRC_VALUE[g*SRC_W +: SRC_W]);
      assign src_fs[g] = SRC_FULL_SCALE[g*SRC_W +: SRC_W];
   end

   // source value to 0..1000 (0.1 %) of its range; zero full scale reads as 0 %
   function automatic logic [10:0] aops_pct(
      input logic [4:0] code,
      input logic signed [15:0] v,
      input logic [15:0] fs
   );
      logic signed [17:0] num;
      logic [17:0] den;
      logic [31:0] q;
      num = 18'sd0;
      den = {2'b00, fs};
      q = 32'h0000_0000;
      if (code == aops_pkg::SRC_SIGNED_TORQUE) begin
         num = 18'(v) + $signed({2'b00, fs});
         den = {1'b0, fs, 1'b0};
      end else if (code == aops_pkg::SRC_ABS_TORQUE) begin
         num = (v < 16'sd0) ? -18'(v) : 18'(v);
      end else begin
         num = (v < 16'sd0) ? 18'sd0 : 18'(v);
      end
      if (num < 18'sd0) begin
         num = 18'sd0;
      end
      if (den != 18'h0_0000) begin
         q = (32'(num) * 32'(aops_pkg::PCT_FULL)) / 32'(den);
      end
      if (q > 32'(aops_pkg::PCT_FULL)) begin
         q = 32'(aops_pkg::PCT_FULL);
      end
      return q[10:0];
   endfunction

   always_comb begin
      st_nxt = st_r;
      st_nxt.reject = 1'b0;
      idx = PARAM_ADDR[7:0];
      wsig = $signed(PARAM_WDATA);
      addr_hit = (PARAM_ADDR[15:8] == aops_pkg::GROUP_STORE) ||
                 (PARAM_ADDR[15:8] == aops_pkg::GROUP_VOLATILE);
      sel_ok = (PARAM_WDATA <= {11'h000, aops_pkg::SRC_CODE_MAX});

      if (PARAM_WE && addr_hit) begin
         case (idx)
            aops_pkg::IDX_TERM_MODE: begin
               if (PARAM_WDATA[15:1] == 15'h0000) begin
                  st_nxt.term_mode = PARAM_WDATA[0];
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_PULSE_SRC: begin
               if (sel_ok) begin
                  st_nxt.pulse_src = PARAM_WDATA[4:0];
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_AO1_SRC: begin
               if (sel_ok) begin
                  st_nxt.ao1_src = PARAM_WDATA[4:0];
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_AO2_SRC: begin
               if (sel_ok) begin
                  st_nxt.ao2_src = PARAM_WDATA[4:0];
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_PULSE_MAX: begin
               if (PARAM_WDATA >= aops_pkg::FREQ_MIN && PARAM_WDATA <= aops_pkg::FREQ_MAX) begin
                  st_nxt.pulse_max = PARAM_WDATA;
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_AO1_OFS: begin
               if (wsig >= aops_pkg::OFS_MIN && wsig <= aops_pkg::OFS_MAX) begin
                  st_nxt.ao1_ofs = wsig;
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_AO1_GAIN: begin
               if (wsig >= aops_pkg::GAIN_MIN && wsig <= aops_pkg::GAIN_MAX) begin
                  st_nxt.ao1_gain = wsig;
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_AO2_OFS: begin
               if (wsig >= aops_pkg::OFS_MIN && wsig <= aops_pkg::OFS_MAX) begin
                  st_nxt.ao2_ofs = wsig;
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            aops_pkg::IDX_AO2_GAIN: begin
               if (wsig >= aops_pkg::GAIN_MIN && wsig <= aops_pkg::GAIN_MAX) begin
                  st_nxt.ao2_gain = wsig;
               end else begin
                  st_nxt.reject = 1'b1;
               end
            end
            default: begin
               // read-only and unmapped indices refuse writes and raise the reject flag
               st_nxt.reject = 1'b1;
            end
         endcase
      end

      // percentages are registered once so the divides sit in their own stage
      st_nxt.pulse_pct = aops_pct(st_r.pulse_src, src_v[st_r.pulse_src],
                                  src_fs[st_r.pulse_src]);
      st_nxt.ao1_pct = aops_pct(st_r.ao1_src, src_v[st_r.ao1_src], src_fs[st_r.ao1_src]);
      st_nxt.ao2_pct = aops_pct(st_r.ao2_src, src_v[st_r.ao2_src], src_fs[st_r.ao2_src]);

      // floor of one step (0.01 kHz) at 0 %, maximum at 100 %
      freq_span = (32'(st_r.pulse_pct) * 32'(st_r.pulse_max - aops_pkg::FREQ_MIN))
                  / 32'(aops_pkg::PCT_FULL);
      if (st_r.term_mode == aops_pkg::TERM_PULSE) begin
         st_nxt.pulse_freq = aops_pkg::FREQ_MIN + freq_span[15:0];
      end else begin
         st_nxt.pulse_freq = 16'h0000;
      end

      st_nxt.rdata = 16'h0000;
      if (addr_hit) begin
         case (idx)
            aops_pkg::IDX_TERM_MODE: st_nxt.rdata = {15'h0000, st_r.term_mode};
            aops_pkg::IDX_PULSE_SRC: st_nxt.rdata = {11'h000, st_r.pulse_src};
            aops_pkg::IDX_AO1_SRC: st_nxt.rdata = {11'h000, st_r.ao1_src};
            aops_pkg::IDX_AO2_SRC: st_nxt.rdata = {11'h000, st_r.ao2_src};
            aops_pkg::IDX_PULSE_MAX: st_nxt.rdata = st_r.pulse_max;
            aops_pkg::IDX_AO1_OFS: st_nxt.rdata = st_r.ao1_ofs;
            aops_pkg::IDX_AO1_GAIN: st_nxt.rdata = st_r.ao1_gain;
            aops_pkg::IDX_AO2_OFS: st_nxt.rdata = st_r.ao2_ofs;
            aops_pkg::IDX_AO2_GAIN: st_nxt.rdata = st_r.ao2_gain;
            aops_pkg::IDX_PULSE_FREQ: st_nxt.rdata = st_r.pulse_freq;
            aops_pkg::IDX_AO1_PCT: st_nxt.rdata = {5'h00, st_r.ao1_pct};
            aops_pkg::IDX_AO2_PCT: st_nxt.rdata = {5'h00, st_r.ao2_pct};
            aops_pkg::IDX_PULSE_PCT: st_nxt.rdata = {5'h00, st_r.pulse_pct};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= '0;
         st_r.term_mode <= aops_pkg::TERM_MODE_RST;
         st_r.pulse_src <= aops_pkg::PULSE_SRC_RST;
         st_r.ao1_src <= aops_pkg::AO1_SRC_RST;
         st_r.ao2_src <= aops_pkg::AO2_SRC_RST;
         st_r.pulse_max <= aops_pkg::FREQ_RST;
         st_r.ao1_ofs <= aops_pkg::OFS_RST;
         st_r.ao1_gain <= aops_pkg::GAIN_RST;
         st_r.ao2_ofs <= aops_pkg::OFS_RST;
         st_r.ao2_gain <= aops_pkg::GAIN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   aops_pulse_gen u_pulse (
      .CORE_CLK(CORE_CLK),
      .RST_B(RST_B),
      .enable(st_r.term_mode == aops_pkg::TERM_PULSE),
      .freq(st_r.pulse_freq),
      .pulse(pulse_wave)
   );

   aops_analog_out u_ao1 (
      .CORE_CLK(CORE_CLK),
      .RST_B(RST_B),
      .pct(st_r.ao1_pct),
      .gain(st_r.ao1_gain),
      .ofs(st_r.ao1_ofs),
      .current_mode(AO1_CURRENT_MODE),
      .level(ANALOG_OUT_FIRST)
   );

   aops_analog_out u_ao2 (
      .CORE_CLK(CORE_CLK),
      .RST_B(RST_B),
      .pct(st_r.ao2_pct),
      .gain(st_r.ao2_gain),
      .ofs(st_r.ao2_ofs),
      .current_mode(AO2_CURRENT_MODE),
      .level(ANALOG_OUT_SECOND)
   );

   // digital mode passes the logic level straight through: no extra latency
   assign SHARED_FREQ_TERMINAL = (st_r.term_mode == aops_pkg::TERM_DIGITAL) ?
                                 SHARED_TERMINAL_DIGITAL_OUT : pulse_wave;
   assign PARAM_RDATA = st_r.rdata;
   assign PARAM_REJECT = st_r.reject;
endmodule
`default_nettype wire

// file: dv/aops_props.sv
// concurrent checks on the scaler parameter port and outputs
`timescale 1ns/1ps
`default_nettype none
module aops_props (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic PARAM_WE,
   input wire logic [15:0] PARAM_ADDR,
   input wire logic [15:0] PARAM_WDATA,
   input wire logic [15:0] PARAM_RDATA,
   input wire logic PARAM_REJECT,
   input wire logic AO1_CURRENT_MODE,
   input wire logic AO2_CURRENT_MODE,
   input wire logic SHARED_TERMINAL_DIGITAL_OUT,
   input wire logic SHARED_FREQ_TERMINAL,
   input wire logic [15:0] ANALOG_OUT_FIRST,
   input wire logic [15:0] ANALOG_OUT_SECOND
);
   logic wr;
   logic [7:0] ix;
   logic signed [15:0] sd;
   logic mode_r;
   assign ix = PARAM_ADDR[7:0];
   assign sd = PARAM_WDATA;
   assign wr = PARAM_WE && (PARAM_ADDR[15:8] == 8'hF5 || PARAM_ADDR[15:8] == 8'h05);
   // shadow of the terminal mode, fed only by writes that must be accepted
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_r <= 1'b0;
      end else if (wr && ix == 8'h00 && PARAM_WDATA <= 16'h0001) begin
         mode_r <= PARAM_WDATA[0];
      end
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   chk_sel_refused: assert property (
      wr && ix inside {8'h06, 8'h07, 8'h08} && PARAM_WDATA > 16'h0010 |=> PARAM_REJECT)
      else $error("select above 16 not refused");
   chk_sel_taken: assert property (
      wr && ix inside {8'h06, 8'h07, 8'h08} && PARAM_WDATA <= 16'h0010 |=> !PARAM_REJECT)
      else $error("legal select refused");
   chk_mode_refused: assert property (
      wr && ix == 8'h00 && PARAM_WDATA > 16'h0001 |=> PARAM_REJECT)
      else $error("terminal mode above 1 not refused");
   chk_pmax_refused: assert property (
      wr && ix == 8'h09 && (PARAM_WDATA == 16'h0000 || PARAM_WDATA > 16'h2710)
      |=> PARAM_REJECT) else $error("pulse maximum out of range not refused");
   chk_gain_refused: assert property (
      wr && ix inside {8'h0B, 8'h0D} && (sd > 16'sd1000 || sd < -16'sd1000)
      |=> PARAM_REJECT) else $error("gain out of range not refused");
   chk_digital_pass: assert property (
      mode_r |-> SHARED_FREQ_TERMINAL == SHARED_TERMINAL_DIGITAL_OUT)
      else $error("digital level not passed to terminal");
   chk_ao1_volt_span: assert property (
      !AO1_CURRENT_MODE [*3] |-> ANALOG_OUT_FIRST <= 16'h2710)
      else $error("first output above 10 V");
   chk_ao2_cur_span: assert property (
      AO2_CURRENT_MODE [*3] |-> ANALOG_OUT_SECOND <= 16'h4E20)
      else $error("second output above 20 mA");
   chk_reset_pmax: assert property (
      $rose(RST_B) && !PARAM_WE && PARAM_ADDR == 16'hF509 |=> PARAM_RDATA == 16'h1388)
      else $error("pulse maximum reset value wrong");
   cover property (wr && ix == 8'h07 ##1 PARAM_REJECT);
   cover property (mode_r ##1 !mode_r);
   cover property (!mode_r && $rose(SHARED_FREQ_TERMINAL));
   cover property (AO1_CURRENT_MODE && ANALOG_OUT_FIRST == 16'h4E20);
endmodule
`default_nettype wire

// file: dv/aops_meter.sv
// bench meter counting rising edges seen on the shared frequency terminal
`timescale 1ns/1ps
`default_nettype none
module aops_meter (
   input wire logic clk,
   input wire logic clr,
   input wire logic sig,
   output logic [15:0] edges
);
   logic last_r;
   // clr held high keeps the count at zero between gate windows
   always_ff @(posedge clk) begin
      last_r <= sig;
      if (clr) begin
         edges <= 16'h0000;
      end else if (sig && !last_r) begin
         edges <= edges + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the analog and pulse output scaler
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int WIN = 20000;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic we = 1'b0;
   logic [15:0] addr = 16'hF509;
   logic [15:0] wdata = 16'h0000;
   logic [17*16-1:0] srcv = '0;
   logic [17*16-1:0] srcf = '0;
   logic cur1 = 1'b0;
   logic cur2 = 1'b0;
   logic dig = 1'b0;
   logic clr = 1'b1;
   logic [15:0] rdata;
   logic rej;
   logic term;
   logic [15:0] ao1;
   logic [15:0] ao2;
   logic [15:0] edges;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   aops_top dut_u (
      .CORE_CLK(clk), .RST_B(rst_b), .PARAM_WE(we), .PARAM_ADDR(addr), .PARAM_WDATA(wdata),
      .PARAM_RDATA(rdata), .PARAM_REJECT(rej), .SRC_VALUE(srcv), .SRC_FULL_SCALE(srcf),
      .AO1_CURRENT_MODE(cur1), .AO2_CURRENT_MODE(cur2), .SHARED_TERMINAL_DIGITAL_OUT(dig),
      .SHARED_FREQ_TERMINAL(term), .ANALOG_OUT_FIRST(ao1), .ANALOG_OUT_SECOND(ao2)
   );
   aops_meter meter_u (.clk(clk), .clr(clr), .sig(term), .edges(edges));
   task automatic complete_run();
      $display("mismatches %0d, comparisons %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // edge counts may gain or lose one edge to the gate phase
   task automatic cmp_near(input string nm, input int e, input logic [15:0] g);
      n_tests++;
      if (g !== 16'(e) && g !== 16'(e - 1) && g !== 16'(e + 1)) begin
         fail_count++;
         $display("wrong value %s expected %0d seen %h", nm, e, g);
      end
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      addr <= 16'hF509;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic r);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
      #1 cmp16("write refusal", {15'h0, r}, {15'h0, rej});
   endtask
   task automatic chkrd(input string nm, input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 cmp16(nm, e, rdata);
   endtask
   function automatic logic [15:0] exp_ao(int code, int v, int fs, int g, int o, bit c);
      int p;
      int y;
      if (code == 3 && v < 0) v = -v;
      if (fs == 0) p = 0;
      else if (code == 16) p = (v + fs) * 1000 / (2 * fs);
      else p = v * 1000 / fs;
      p = p < 0 ? 0 : (p > 1000 ? 1000 : p);
      y = g * p / 100 + o;
      y = y < 0 ? 0 : (y > 1000 ? 1000 : y);
      return 16'(y * int'(c ? aops_pkg::YMAX_UA : aops_pkg::YMAX_MV) / 1000);
   endfunction
   task automatic ao_case(input bit s, input int code, input int v, input int fs, input int g,
                          input int o, input bit c);
      wr({8'hF5, s ? 8'h08 : 8'h07}, 16'(code), 1'b0);
      wr({8'hF5, s ? 8'h0D : 8'h0B}, 16'(g), 1'b0);
      wr({8'hF5, s ? 8'h0C : 8'h0A}, 16'(o), 1'b0);
      @(posedge clk);
      srcv[code*16+:16] <= 16'(v);
      srcf[code*16+:16] <= 16'(fs);
      if (s) cur2 <= c;
      else cur1 <= c;
      repeat (4) @(posedge clk);
      #1 cmp16("analog output", exp_ao(code, v, fs, g, o, c), s ? ao2 : ao1);
   endtask
   task automatic t_reset();
      logic [7:0] ix [9] = '{8'h00, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
      logic [15:0] ev [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h1388, 16'h0000,
                              16'h0064, 16'h0000, 16'h0064};
      for (int i = 0; i < 9; i++) begin
         chkrd("reset value", {8'hF5, ix[i]}, ev[i]);
      end
   endtask
   task automatic t_refuse();
      logic [32:0] tv [14] = '{{16'hF507, 16'h0010, 1'b0}, {16'hF507, 16'h0011, 1'b1},
         {16'hF506, 16'h0011, 1'b1}, {16'hF508, 16'h0011, 1'b1}, {16'h1207, 16'h0005, 1'b0},
         {16'h0500, 16'h0002, 1'b1}, {16'hF509, 16'h0000, 1'b1}, {16'h0509, 16'h2711, 1'b1},
         {16'hF509, 16'h2710, 1'b0}, {16'hF50B, 16'h03E9, 1'b1}, {16'hF50D, 16'hFC17, 1'b1},
         {16'hF50A, 16'hFC18, 1'b0}, {16'hF530, 16'h0001, 1'b1}, {16'hF520, 16'h0001, 1'b1}};
      for (int i = 0; i < 14; i++) begin
         wr(tv[i][32:17], tv[i][16:1], tv[i][0]);
      end
      chkrd("kept select", 16'hF507, 16'h0010);
      chkrd("kept mode", 16'hF500, 16'h0000);
      chkrd("pulse maximum", 16'hF509, 16'h2710);
      chkrd("offset", 16'hF50A, 16'hFC18);
   endtask
   task automatic t_sources();
      for (int k = 0; k < 16; k++) begin
         ao_case(k[0], k, k * 100, 2000, 100, 0, 1'b0);
      end
      ao_case(1'b1, 16, -200, 200, 100, 0, 1'b0);
      ao_case(1'b1, 16, 100, 200, 100, 0, 1'b1);
      ao_case(1'b0, 3, -100, 200, 100, 0, 1'b0);
      ao_case(1'b0, 0, -100, 200, 100, 0, 1'b0);
      ao_case(1'b0, 1, 40, 50, -50, 800, 1'b0);
      ao_case(1'b0, 1, 0, 50, -50, 800, 1'b0);
      ao_case(1'b1, 2, 0, 100, 0, 1000, 1'b1);
      ao_case(1'b0, 2, 0, 100, 0, 1000, 1'b0);
      ao_case(1'b0, 4, 60, 100, 1000, 0, 1'b1);
      ao_case(1'b0, 5, 100, 100, -1000, 0, 1'b0);
   endtask
   task automatic t_digital();
      wr(16'hF500, 16'h0001, 1'b0);
      wr(16'hF509, 16'h2710, 1'b0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         dig <= i[0];
         @(posedge clk);
         #1 cmp16("terminal level", {15'h0, i[0]}, {15'h0, term});
      end
      chkrd("pulse frequency", 16'hF520, 16'h0000);
      wr(16'hF500, 16'h0000, 1'b0);
   endtask
   task automatic pulse_case(input int mx, input int v);
      int fr;
      fr = 1 + v * (mx - 1) / 1000;
      wr(16'hF509, 16'(mx), 1'b0);
      wr(16'hF506, 16'h0009, 1'b0);
      @(posedge clk);
      srcv[9*16+:16] <= 16'(v);
      srcf[9*16+:16] <= 16'h03E8;
      repeat (10) @(posedge clk);
      chkrd("pulse frequency", 16'hF520, 16'(fr));
      clr <= 1'b0;
      repeat (WIN) @(posedge clk);
      #1 cmp_near("pulse edges", fr * WIN / (aops_pkg::CLK_HZ / aops_pkg::FREQ_LSB_HZ),
                  edges);
      clr <= 1'b1;
   endtask
   initial begin
      do_reset();
      t_reset();
      t_refuse();
      do_reset();
      t_reset();
      t_sources();
      t_digital();
      pulse_case(10000, 1000);
      pulse_case(5000, 500);
      pulse_case(10000, 0);
      complete_run();
   end
   // the run needs about 60400 cycles; beyond the ceiling it has hung
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fail_count++;
         complete_run();
      end
   end
endmodule
bind aops_top aops_props chk_u (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PARAM_WE(PARAM_WE), .PARAM_ADDR(PARAM_ADDR),
   .PARAM_WDATA(PARAM_WDATA), .PARAM_RDATA(PARAM_RDATA), .PARAM_REJECT(PARAM_REJECT),
   .AO1_CURRENT_MODE(AO1_CURRENT_MODE), .AO2_CURRENT_MODE(AO2_CURRENT_MODE),
   .SHARED_TERMINAL_DIGITAL_OUT(SHARED_TERMINAL_DIGITAL_OUT),
   .SHARED_FREQ_TERMINAL(SHARED_FREQ_TERMINAL), .ANALOG_OUT_FIRST(ANALOG_OUT_FIRST),
   .ANALOG_OUT_SECOND(ANALOG_OUT_SECOND)
);
`default_nettype wire
